// ==== bench/ata_taskfile_status_control_tb.sv ====
`timescale 1ns/100ps
module ata_taskfile_status_control_tb;
    logic clk = 1'b0, rst = 1'b1, card_mode, copy_field, ide_card_id;
    logic core_busy, core_ready, core_write_fault, core_data_req, core_error;
    logic core_corrected, core_cmd_done, host_rd, host_wr, host_rvalid_r;
    logic irq_r, cfg_int_r, soft_reset_r, card_selected_r, lba_mode_r;
    atsc_pkg::atsc_offset_t host_addr;
    atsc_pkg::atsc_head_t head_lba_r;
    atsc_pkg::atsc_byte_t host_wdata, host_rdata_r, core_error_code, w, last;
    logic [31:0] r, seed = 32'h0000_0052;
    int err_count = 0, checked = 0;
    wire logic own = card_mode ? copy_field : ide_card_id;
    atsc_regs i_atsc_regs (.clk, .rst, .host_rd, .host_wr, .host_addr,
        .host_wdata, .host_rdata_r, .host_rvalid_r, .card_mode, .copy_field,
        .ide_card_id, .core_busy, .core_ready, .core_write_fault,
        .core_data_req, .core_corrected, .core_cmd_done, .core_error,
        .core_error_code, .irq_r, .cfg_int_r, .soft_reset_r,
        .card_selected_r, .lba_mode_r, .head_lba_r);
    atsc_host i_atsc_host (.clk, .host_rd, .host_wr, .host_addr, .host_wdata,
        .host_rdata_r, .host_rvalid_r);
    initial forever #12.5 clk = ~clk;
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 4000);
        err_count++;
        finish_test();
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e, string n);
        logic [7:0] v;
        i_atsc_host.rd(a, v);
        chk(n, v, e);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    function automatic logic [7:0] st(input logic c);
        return {1'b0, core_ready, core_write_fault, core_ready,
            core_data_req, c, 1'b0, core_error};
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    initial begin
        {core_busy, core_ready, core_write_fault, core_data_req} = '0;
        {core_error, core_corrected, core_cmd_done, card_mode} = '0;
        {copy_field, ide_card_id, core_error_code, last} = '0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rc(4'h7, 8'h00, "ready");
        rc(4'h2, 8'h00, "unmapped");
        for (int i = 0; i < 32; i++) begin
            r = (i == 0) ? 32'hffff_ffff : xs();
            {core_ready, core_write_fault, core_data_req, core_error} = r[3:0];
            {card_mode, copy_field, ide_card_id} = r[6:4];
            {core_error_code, w} = r[23:8];
            if (core_error) last = core_error_code;
            rc(4'h7, st(1'b0), "status");
            rc(4'hd, last, "error");
            i_atsc_host.wr(4'h6, w);
            rc(4'h6, w | 8'ha0, "drive_head");
            chk("head", head_lba_r, w[3:0]);
            chk("lba", lba_mode_r, w[6]);
            chk("sel", card_selected_r, w[4] == own);
        end
        {core_ready, core_write_fault, core_data_req, core_error} = '0;
        core_busy = 1'b1;
        rc(4'h7, 8'h80, "busy");
        i_atsc_host.wr(4'h6, ~w);
        core_busy = 1'b0;
        rc(4'h6, w | 8'ha0, "locked");
        pulse(core_corrected);
        rc(4'h7, st(1'b1), "corrected_data_flag");
        pulse(core_cmd_done);
        chk("irq", irq_r, 1'b1);
        chk("cfg_int", cfg_int_r, 1'b1);
        rc(4'he, st(1'b0), "alt");
        rc(4'h7, st(1'b0), "st_clr");
        chk("irq_clr", irq_r, 1'b0);
        i_atsc_host.wr(4'he, 8'hfa);
        pulse(core_cmd_done);
        chk("irq_off", irq_r, 1'b0);
        i_atsc_host.wr(4'he, 8'h09);
        pulse(core_cmd_done);
        chk("irq_on", irq_r, 1'b1);
        chk("srst_ign", soft_reset_r, 1'b0);
        i_atsc_host.wr(4'he, 8'h04);
        repeat (2) @(negedge clk);
        chk("srst_on", soft_reset_r, 1'b1);
        rc(4'h7, 8'h80, "srst");
        i_atsc_host.wr(4'he, 8'h00);
        repeat (2) @(negedge clk);
        rc(4'h6, 8'ha0, "dh_srst");
        i_atsc_host.wr(4'he, 8'h02);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        pulse(core_cmd_done);
        chk("ien_rst", irq_r, 1'b1);
        finish_test();
    end
endmodule

// ==== bench/atsc_host.sv ====
`timescale 1ns/100ps
module atsc_host (
    input wire logic clk,
    output logic host_rd,
    output logic host_wr,
    output atsc_pkg::atsc_offset_t host_addr,
    output atsc_pkg::atsc_byte_t host_wdata,
    input wire atsc_pkg::atsc_byte_t host_rdata_r,
    input wire logic host_rvalid_r
);
    initial {host_rd, host_wr, host_addr, host_wdata} = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        {host_addr, host_wdata, host_wr} = {a, v, 1'b1};
        @(negedge clk);
        {host_wdata, host_wr} = {~v, 1'b0};
    endtask
    // data only trusted with the valid pulse
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge clk);
        {host_addr, host_rd} = {a, 1'b1};
        @(negedge clk);
        // answer stands only in the cycle after the read edge
        v = host_rvalid_r ? host_rdata_r : 8'hxx;
        host_rd = 1'b0;
    endtask
endmodule

// ==== bench/atsc_regs_properties.sv ====
`timescale 1ns/100ps
module atsc_regs_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire atsc_pkg::atsc_offset_t host_addr,
    input wire atsc_pkg::atsc_byte_t host_wdata,
    input wire atsc_pkg::atsc_byte_t host_rdata_r,
    input wire logic core_busy,
    input wire logic core_cmd_done,
    input wire logic core_data_req,
    input wire logic irq_r,
    input wire logic soft_reset_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rs = host_rd && host_addr == 4'h7;
    wire logic wc = host_wr && host_addr == 4'he;
    property p_clr;
        rs && !core_cmd_done && !core_data_req |=> !irq_r;
    endproperty
    a_clr: assert property (p_clr) else $error("irq kept");
    property p_alt;
        host_rd && host_addr == 4'he && irq_r && !soft_reset_r && !host_wr
            && !$past(host_wr) && !$past(host_wr, 2) |=> irq_r;
    endproperty
    a_alt: assert property (p_alt) else $error("irq lost");
    property p_busy;
        rs && core_busy |=> host_rdata_r == 8'h80;
    endproperty
    a_busy: assert property (p_busy) else $error("busy byte");
    property p_idx;
        rs |=> !host_rdata_r[1];
    endproperty
    a_idx: assert property (p_idx) else $error("index set");
    property p_dsc;
        rs |=> host_rdata_r[4] == host_rdata_r[6];
    endproperty
    a_dsc: assert property (p_dsc) else $error("seek flag");
    property p_mask;
        wc && host_wdata[1] ##1 !wc |=> !irq_r;
    endproperty
    a_mask: assert property (p_mask) else $error("irq unmasked");
    property p_srst;
        wc ##1 !wc |=> soft_reset_r == $past(host_wdata[2], 2);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset");
    property p_rst;
        $fell(rst) |-> !irq_r && !soft_reset_r;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind atsc_regs atsc_regs_properties i_atsc_regs_properties (.clk, .rst,
    .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata_r, .core_busy,
    .core_cmd_done, .core_data_req, .irq_r, .soft_reset_r);

// ==== include/atsc_params.svh ====
`ifndef ATSC_PARAMS_SVH
`define ATSC_PARAMS_SVH

// host-visible offsets
`define ATSC_OFS_ERROR      4'h1
`define ATSC_OFS_ERROR_DUP  4'hd
`define ATSC_OFS_DRIVE_HEAD 4'h6
`define ATSC_OFS_STATUS     4'h7
`define ATSC_OFS_ALT_CTRL   4'he

// drive/head fields
`define ATSC_DH_ONE7       7
`define ATSC_DH_LBA        6
`define ATSC_DH_ONE5       5
`define ATSC_DH_DRV        4
`define ATSC_DH_HEAD_HI    3
`define ATSC_DH_HEAD_LO    0
`define ATSC_DH_RESET      8'ha0
`define ATSC_DH_FIXED_MASK 8'ha0

// status fields
`define ATSC_ST_BUSY 7
`define ATSC_ST_RDY  6
`define ATSC_ST_DWF  5
`define ATSC_ST_DSC  4
`define ATSC_ST_DRQ  3
`define ATSC_ST_CORRECTED_DATA_FLAG 2
`define ATSC_ST_IDX  1
`define ATSC_ST_ERR  0

// device control fields
`define ATSC_DC_SRST 2
`define ATSC_DC_IDIS 1
`define ATSC_DC_RESET 2'h0

`define ATSC_BYTE_ZERO 8'h00

`endif

// ==== include/atsc_pkg.sv ====
package atsc_pkg;
    typedef logic [7:0] atsc_byte_t;
    typedef logic [3:0] atsc_offset_t;
    typedef logic [3:0] atsc_head_t;
    // what a host read returns
    typedef enum logic [2:0] {
        ATSC_SEL_NONE   = 3'b000,
        ATSC_SEL_STATUS = 3'b001,
        ATSC_SEL_ALT    = 3'b010,
        ATSC_SEL_DH     = 3'b011,
        ATSC_SEL_ERROR  = 3'b100
    } atsc_rsel_t;
endpackage

// ==== logic/atsc_hold.sv ====
`timescale 1ns/100ps
// loadable holding register with synchronous clear to a reset value
module atsc_hold #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    always_ff @(posedge clk) begin
        if (clear) begin
            q <= RESET_VAL;
        end else if (load) begin
            q <= d;
        end
    end
endmodule

// ==== logic/atsc_regs.sv ====
`timescale 1ns/100ps
`include "atsc_params.svh"
module atsc_regs (
    input wire logic clk,
    input wire logic rst,
    // host register port, strobes on this clock
    input wire logic host_rd,
    input wire logic host_wr,
    input wire atsc_pkg::atsc_offset_t host_addr,
    input wire atsc_pkg::atsc_byte_t host_wdata,
    output atsc_pkg::atsc_byte_t host_rdata_r,
    output logic host_rvalid_r,
    // card configuration side
    input wire logic card_mode,
    input wire logic copy_field,
    input wire logic ide_card_id,
    // controller core side
    input wire logic core_busy,
    input wire logic core_ready,
    input wire logic core_write_fault,
    input wire logic core_data_req,
    input wire logic core_corrected,
    input wire logic core_cmd_done,
    input wire logic core_error,
    input wire atsc_pkg::atsc_byte_t core_error_code,
    // outputs
    output logic irq_r,
    output logic cfg_int_r,
    output logic soft_reset_r,
    output logic card_selected_r,
    output logic lba_mode_r,
    output atsc_pkg::atsc_head_t head_lba_r
);
    // held registers
    atsc_pkg::atsc_byte_t dh_q;
    atsc_pkg::atsc_byte_t err_q;
    logic [1:0] dc_q;
    logic corrected_data_flag_r;
    logic corrected_data_flag_nxt;
    logic irq_pend_r;
    logic irq_pend_nxt;
    logic drq_prev_r;

    // address decode
    wire hit_status = host_addr == `ATSC_OFS_STATUS;
    wire hit_alt_ctrl = host_addr == `ATSC_OFS_ALT_CTRL;
    wire hit_dh = host_addr == `ATSC_OFS_DRIVE_HEAD;
    wire hit_err = (host_addr == `ATSC_OFS_ERROR) ||
        (host_addr == `ATSC_OFS_ERROR_DUP);

    wire srst = dc_q[1];
    wire ien_dis = dc_q[0];
    // controller owns registers while busy or in soft reset
    wire busy = core_busy || srst;
    wire ready = core_ready && !busy;

    // write and status-read decode
    wire wr_ctrl = host_wr && hit_alt_ctrl;
    wire wr_dh = host_wr && hit_dh && !busy;
    wire rd_status = host_rd && hit_status;

    // only soft reset and interrupt disable are kept
    wire [1:0] dc_d = {host_wdata[`ATSC_DC_SRST],
        host_wdata[`ATSC_DC_IDIS]};
    // fixed ones forced on the drive/head byte
    wire [7:0] dh_d = host_wdata | `ATSC_DH_FIXED_MASK;

    atsc_hold #(
        .WIDTH(2),
        .RESET_VAL(`ATSC_DC_RESET)
    ) u_ctrl (
        .clk(clk),
        .clear(rst),
        .load(wr_ctrl),
        .d(dc_d),
        .q(dc_q)
    );

    // soft reset clears drive/head; configuration lives elsewhere
    atsc_hold #(
        .WIDTH(8),
        .RESET_VAL(`ATSC_DH_RESET)
    ) u_drive_head (
        .clk(clk),
        .clear(rst || srst),
        .load(wr_dh),
        .d(dh_d),
        .q(dh_q)
    );

    atsc_hold #(
        .WIDTH(8),
        .RESET_VAL(`ATSC_BYTE_ZERO)
    ) u_error (
        .clk(clk),
        .clear(rst || srst),
        .load(core_error),
        .d(core_error_code),
        .q(err_q)
    );

    // status byte assembly
    atsc_pkg::atsc_byte_t status;
    always_comb begin
        status = `ATSC_BYTE_ZERO;
        status[`ATSC_ST_BUSY] = busy;
        if (!busy) begin
            status[`ATSC_ST_RDY] = ready;
            status[`ATSC_ST_DWF] = core_write_fault;
            status[`ATSC_ST_DSC] = ready;
            status[`ATSC_ST_DRQ] = core_data_req;
            status[`ATSC_ST_CORRECTED_DATA_FLAG] = corrected_data_flag_r;
            status[`ATSC_ST_ERR] = core_error;
        end
        status[`ATSC_ST_IDX] = 1'b0;
    end

    // read selection; busy turns drive/head and error reads into status
    atsc_pkg::atsc_rsel_t rsel;
    always_comb begin
        if (hit_status) begin
            rsel = atsc_pkg::ATSC_SEL_STATUS;
        end else if (hit_alt_ctrl) begin
            rsel = atsc_pkg::ATSC_SEL_ALT;
        end else if (hit_dh) begin
            rsel = busy ? atsc_pkg::ATSC_SEL_STATUS
                : atsc_pkg::ATSC_SEL_DH;
        end else if (hit_err) begin
            rsel = busy ? atsc_pkg::ATSC_SEL_STATUS
                : atsc_pkg::ATSC_SEL_ERROR;
        end else begin
            rsel = atsc_pkg::ATSC_SEL_NONE;
        end
    end

    atsc_pkg::atsc_byte_t rdata_nxt;
    always_comb begin
        unique case (rsel)
            atsc_pkg::ATSC_SEL_STATUS: rdata_nxt = status;
            atsc_pkg::ATSC_SEL_ALT: rdata_nxt = status;
            atsc_pkg::ATSC_SEL_DH: rdata_nxt = dh_q;
            atsc_pkg::ATSC_SEL_ERROR: rdata_nxt = err_q;
            default: rdata_nxt = `ATSC_BYTE_ZERO;
        endcase
    end

    // corrected flag: set on correction, cleared by status read;
    // the core keeps streaming sectors regardless
    always_comb begin
        corrected_data_flag_nxt = corrected_data_flag_r;
        if (rd_status) begin
            corrected_data_flag_nxt = 1'b0;
        end
        if (core_corrected) begin
            corrected_data_flag_nxt = 1'b1;
        end
        if (srst) begin
            corrected_data_flag_nxt = 1'b0;
        end
    end

    // interrupt pending: set wins over the status-read clear
    wire drq_rise = core_data_req && !drq_prev_r;
    wire irq_event = (core_cmd_done || drq_rise) && !ien_dis;
    always_comb begin
        irq_pend_nxt = irq_pend_r;
        if (rd_status) begin
            irq_pend_nxt = 1'b0;
        end
        if (irq_event) begin
            irq_pend_nxt = 1'b1;
        end
        if (srst) begin
            irq_pend_nxt = 1'b0;
        end
    end

    // card number from copy field in card mode, strap otherwise
    wire card_id = card_mode ? copy_field : ide_card_id;
    wire sel_match = dh_q[`ATSC_DH_DRV] == card_id;

    always_ff @(posedge clk) begin
        if (rst) begin
            corrected_data_flag_r <= 1'b0;
            irq_pend_r <= 1'b0;
            drq_prev_r <= 1'b0;
        end else begin
            corrected_data_flag_r <= corrected_data_flag_nxt;
            irq_pend_r <= irq_pend_nxt;
            drq_prev_r <= core_data_req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_rdata_r <= `ATSC_BYTE_ZERO;
            host_rvalid_r <= 1'b0;
        end else begin
            host_rdata_r <= host_rd ? rdata_nxt : `ATSC_BYTE_ZERO;
            host_rvalid_r <= host_rd;
        end
    end

    // interrupt outputs gated by disable bit; soft reset output follows dc_q[1] ungated
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;
            cfg_int_r <= 1'b0;
            soft_reset_r <= 1'b0;
        end else begin
            irq_r <= irq_pend_nxt && !dc_q[0];
            cfg_int_r <= irq_pend_nxt && !dc_q[0];
            soft_reset_r <= dc_q[1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            card_selected_r <= 1'b0;
            lba_mode_r <= 1'b0;
            head_lba_r <= '0;
        end else begin
            card_selected_r <= sel_match;
            lba_mode_r <= dh_q[`ATSC_DH_LBA];
            head_lba_r <= dh_q[`ATSC_DH_HEAD_HI:`ATSC_DH_HEAD_LO];
        end
    end
endmodule
